// ===== logic/shp_port_ctrl.sv
// Serial host port: frames host words, writes channel control, queues
// transmit words and drives the open-drain attention line.
// Assumes the host is serial clock master and a 100 MHz system clock.
//
// Summary of operation
// - Reset low forces all registers to defaults
// - Serial traffic accepted only while select low
// - Select high: serial clock and data ignored
// - Select rising edge completes the transaction
// - Attention driven low on enabled condition
// - Attention is open-drain, shared wired-OR line
// - Data input captured on serial clock rise
// - Data output changes on serial clock fall
// - Two-bit code selects per-channel bit deviation
// - Interrupt on transmit empty or receive nonempty
// - Interrupt clearing evaluated at each word end
// - Single bytes and bursts in one frame
`timescale 1ns/1ps
module shp_port_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  output logic attnOut,
  output logic attnOe,
  input wire logic [1:0] txEmpty,
  input wire logic [1:0] rxNotEmpty,
  output logic [7:0] txData,
  output logic txChan,
  output logic txValid,
  input wire logic txReady,
  output logic [3:0] spreadDeviationSelect,
  output logic [15:0] devCycles
);

  // ----------------------------------------
  // Deviation code to cycle count
  // ----------------------------------------
  function automatic logic [7:0] dev_cycles(input logic [1:0] code);
    logic [7:0] c;
    c = 8'h00;
    if (code == shp_pkg::DEV_NARROW)
      c = 8'(shp_pkg::DEV_NARROW_CYC);
    else if (code == shp_pkg::DEV_WIDE)
      c = 8'(shp_pkg::DEV_WIDE_CYC);
    return c;
  endfunction

  // ----------------------------------------
  // Serial clock domain
  // ----------------------------------------
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [6:0] shiftIn_reg, shiftIn_next;
  logic [7:0] wordHold_reg, wordHold_next;
  logic wordTgl_reg, wordTgl_next;
  logic misoOut_reg, misoOut_next;
  logic [7:0] statS1_reg, statS2_reg;
  logic [7:0] statusByte;

  // Count bits and capture data on the rising edge
  always_comb
  begin
    bitCnt_next = 3'(bitCnt_reg + 3'h1);
    shiftIn_next = {shiftIn_reg[5:0], mosi};
    wordHold_next = wordHold_reg;
    wordTgl_next = wordTgl_reg;
    if (bitCnt_reg == 3'h7)
    begin
      wordHold_next = {shiftIn_reg, mosi};
      wordTgl_next = !wordTgl_reg;
    end
  end

  // Frame counters cleared while select is high
  always_ff @(posedge spiClk or posedge csN or negedge resetn)
  begin
    if (!resetn || csN)
    begin
      bitCnt_reg <= 3'h0;
      shiftIn_reg <= 7'h00;
    end
    else
    begin
      bitCnt_reg <= bitCnt_next;
      shiftIn_reg <= shiftIn_next;
    end
  end

  // Completed word and its toggle survive the frame end
  always_ff @(posedge spiClk or negedge resetn)
  begin
    if (!resetn)
    begin
      wordHold_reg <= 8'h00;
      wordTgl_reg <= 1'b0;
    end
    else
    begin
      wordHold_reg <= wordHold_next;
      wordTgl_reg <= wordTgl_next;
    end
  end

  // Status bits brought onto the serial clock
  always_ff @(posedge spiClk or negedge resetn)
  begin
    if (!resetn)
    begin
      statS1_reg <= 8'h00;
      statS2_reg <= 8'h00;
    end
    else
    begin
      statS1_reg <= statusByte;
      statS2_reg <= statS1_reg;
    end
  end

  // Next output bit, most significant first
  always_comb
  begin
    misoOut_next = statS2_reg[3'h7 - bitCnt_reg];
  end

  // Output bit changes on the falling edge, cleared while select is high
  always_ff @(negedge spiClk or posedge csN or negedge resetn)
  begin
    if (!resetn || csN)
      misoOut_reg <= 1'b0;
    else
      misoOut_reg <= misoOut_next;
  end

  assign miso = misoOut_reg;

  // ----------------------------------------
  // Crossing into the system clock
  // ----------------------------------------
  logic [2:0] csSync_reg, csSync_next;
  logic [2:0] tglSync_reg, tglSync_next;
  logic csStable_reg, csStable_next;
  logic tglSeen_reg, tglSeen_next;
  logic [7:0] word_reg, word_next;
  logic csRise, wordDone;

  // Three-stage synchronisers, change taken when last two agree
  always_comb
  begin
    csSync_next = {csSync_reg[1:0], csN};
    tglSync_next = {tglSync_reg[1:0], wordTgl_reg};
    csStable_next = csStable_reg;
    if (csSync_reg[1] == csSync_reg[2])
      csStable_next = csSync_reg[2];
    tglSeen_next = tglSeen_reg;
    word_next = word_reg;
    if (tglSync_reg[1] == tglSync_reg[2] && tglSync_reg[2] != tglSeen_reg)
    begin
      tglSeen_next = tglSync_reg[2];
      word_next = wordHold_reg; // Stable for seven more serial clocks
    end
  end

  // Register the crossing stages
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      csSync_reg <= 3'h7;
      tglSync_reg <= 3'h0;
      csStable_reg <= 1'b1;
      tglSeen_reg <= 1'b0;
      word_reg <= 8'h00;
    end
    else
    begin
      csSync_reg <= csSync_next;
      tglSync_reg <= tglSync_next;
      csStable_reg <= csStable_next;
      tglSeen_reg <= tglSeen_next;
      word_reg <= word_next;
    end
  end

  // One-cycle events: frame end and word arrival
  logic csStableD_reg, wordPend_reg;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      csStableD_reg <= 1'b1;
      wordPend_reg <= 1'b0;
    end
    else
    begin
      csStableD_reg <= csStable_reg;
      wordPend_reg <= tglSeen_next != tglSeen_reg;
    end
  end
  assign csRise = csStable_reg && !csStableD_reg;
  assign wordDone = wordPend_reg;

  // ----------------------------------------
  // Word decoder and channel control
  // ----------------------------------------
  shp_pkg::shp_phase_t phase_reg, phase_next;
  logic [1:0] sel_reg, sel_next;
  logic [7:0] ctrl_reg [shp_pkg::NUM_CH];
  logic [7:0] ctrl_next [shp_pkg::NUM_CH];
  logic [8:0] pend_reg, pend_next;
  logic pendV_reg, pendV_next;
  logic lost_reg, lost_next;
  logic bufInReady;

  // Command byte picks a target, later bytes of the burst go to it
  always_comb
  begin
    phase_next = phase_reg;
    sel_next = sel_reg;
    ctrl_next = ctrl_reg;
    pend_next = pend_reg;
    pendV_next = pendV_reg && !bufInReady;
    lost_next = lost_reg;
    if (wordDone)
    begin
      unique case (phase_reg)
        shp_pkg::PH_CMD:
        begin
          sel_next = word_reg[shp_pkg::CMD_SEL_LSB +: 2];
          phase_next = shp_pkg::PH_DATA;
          lost_next = 1'b0;
        end
        shp_pkg::PH_DATA:
        begin
          if (sel_reg == shp_pkg::SEL_CTRL0 || sel_reg == shp_pkg::SEL_CTRL1)
            ctrl_next[sel_reg[0]] = word_reg;
          else if (pendV_next)
            lost_next = 1'b1; // Previous word still waiting
          else
          begin
            pend_next = {sel_reg == shp_pkg::SEL_TX1, word_reg};
            pendV_next = 1'b1;
          end
        end
      endcase
    end
    if (csRise)
      phase_next = shp_pkg::PH_CMD;
  end

  // Register decoder state
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      phase_reg <= shp_pkg::PH_CMD;
      sel_reg <= 2'h0;
      ctrl_reg <= '{default: shp_pkg::CTRL_RESET};
      pend_reg <= 9'h000;
      pendV_reg <= 1'b0;
      lost_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      sel_reg <= sel_next;
      ctrl_reg <= ctrl_next;
      pend_reg <= pend_next;
      pendV_reg <= pendV_next;
      lost_reg <= lost_next;
    end
  end

  // Transmit words stall in the pending slot until the buffer has room
  logic [8:0] bufOut;
  shp_pair_buffer #(.W(shp_pkg::BUF_W)) txBuf (
    .clk(clk),
    .resetn(resetn),
    .inData(pend_reg),
    .inValid(pendV_reg),
    .inReady(bufInReady),
    .outData(bufOut),
    .outValid(txValid),
    .outReady(txReady)
  );
  assign txData = bufOut[7:0];
  assign txChan = bufOut[8];

  // ----------------------------------------
  // Per-channel attention and deviation
  // ----------------------------------------
  logic [1:0] chReq;
  logic [3:0] devSel_next;
  logic [15:0] devCyc_next;
  genvar ch;
  generate
    for (ch = 0; ch < shp_pkg::NUM_CH; ch++)
    begin : gCh
      assign chReq[ch] = (txEmpty[ch] && ctrl_reg[ch][shp_pkg::CTRL_TXE_EN]) ||
        (rxNotEmpty[ch] && ctrl_reg[ch][shp_pkg::CTRL_RXNE_EN]);
      assign devSel_next[2*ch +: 2] = ctrl_reg[ch][shp_pkg::CTRL_DEV_LSB +: 2];
      assign devCyc_next[8*ch +: 8] = dev_cycles(devSel_next[2*ch +: 2]);
    end
  endgenerate

  // Attention sets on any enabled request, releases only at a word end or a frame end
  logic attn_reg, attn_next;
  logic misoOe_reg, misoOe_next;
  always_comb
  begin
    attn_next = attn_reg;
    if (|chReq)
      attn_next = 1'b1;
    else if (wordDone || csRise)
      attn_next = 1'b0;
    misoOe_next = !csStable_reg;
  end

  // Register pin-facing outputs
  logic [3:0] devSel_reg;
  logic [15:0] devCyc_reg;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      attn_reg <= 1'b0;
      misoOe_reg <= 1'b0;
      devSel_reg <= 4'h0;
      devCyc_reg <= 16'h0000;
    end
    else
    begin
      attn_reg <= attn_next;
      misoOe_reg <= misoOe_next;
      devSel_reg <= devSel_next;
      devCyc_reg <= devCyc_next;
    end
  end

  // Open-drain pin: drives only low, pull-up sits outside
  assign attnOut = 1'b0;
  assign attnOe = attn_reg;
  assign misoOe = misoOe_reg;
  assign spreadDeviationSelect = devSel_reg;
  assign devCycles = devCyc_reg;

  // Status returned to the host on every byte
  assign statusByte = {1'b0, lost_reg, pendV_reg, rxNotEmpty, txEmpty, attn_reg};

endmodule

// ===== logic/shp_pkg.sv
// Shared constants for the serial host port controller.
// Assumes a 100 MHz system clock; the serial clock comes from the host.
package shp_pkg;

  // ----------------------------------------
  // Widths and channel count
  // ----------------------------------------
  localparam int NUM_CH = 2;
  localparam int WORD_W = 8;
  localparam int BUF_W = 9; // Channel bit above eight data bits

  // ----------------------------------------
  // Command byte layout
  // ----------------------------------------
  localparam int CMD_SEL_LSB = 0; // Two-bit target select
  localparam logic [1:0] SEL_CTRL0 = 2'h0;
  localparam logic [1:0] SEL_CTRL1 = 2'h1;
  localparam logic [1:0] SEL_TX0 = 2'h2;
  localparam logic [1:0] SEL_TX1 = 2'h3;

  // ----------------------------------------
  // Channel control layout and reset value
  // ----------------------------------------
  localparam int CTRL_TXE_EN = 0;
  localparam int CTRL_RXNE_EN = 1;
  localparam int CTRL_DEV_LSB = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------
  // Status byte layout (bit 7 always reads zero)
  // ----------------------------------------
  localparam int STAT_ATTN = 0;
  localparam int STAT_TXE_LSB = 1;
  localparam int STAT_RXNE_LSB = 3;
  localparam int STAT_BUSY = 5;
  localparam int STAT_LOST = 6;

  // ----------------------------------------
  // Spread deviation codes and times
  // ----------------------------------------
  localparam logic [1:0] DEV_WIDE = 2'h1;
  localparam logic [1:0] DEV_NARROW = 2'h2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEV_NARROW_NS = 400;
  localparam int DEV_WIDE_NS = 800;
  localparam int DEV_NARROW_CYC = (DEV_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEV_WIDE_CYC = (DEV_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Decoder phases
  // ----------------------------------------
  typedef enum logic {PH_CMD, PH_DATA} shp_phase_t;

endpackage

// ===== logic/shp_pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module shp_pair_buffer #(
  parameter int W = shp_pkg::BUF_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  logic [W-1:0] head_reg, head_next, tail_reg, tail_next;
  logic headV_reg, headV_next, tailV_reg, tailV_next;
  logic push, pop;

  // ----------------------------------------
  // Head is the output entry, tail the spare
  // ----------------------------------------
  always_comb
  begin
    push = inValid && !tailV_reg;
    pop = headV_reg && outReady;
    head_next = head_reg;
    tail_next = tail_reg;
    headV_next = headV_reg;
    tailV_next = tailV_reg;
    if (pop)
    begin
      headV_next = tailV_reg || push;
      head_next = tailV_reg ? tail_reg : inData;
      tailV_next = tailV_reg && push;
      if (tailV_reg && push)
        tail_next = inData;
    end
    else if (push)
    begin
      if (headV_reg)
      begin
        tail_next = inData;
        tailV_next = 1'b1;
      end
      else
      begin
        head_next = inData;
        headV_next = 1'b1;
      end
    end
  end

  // Register both entries
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      head_reg <= '0;
      tail_reg <= '0;
      headV_reg <= 1'b0;
      tailV_reg <= 1'b0;
    end
    else
    begin
      head_reg <= head_next;
      tail_reg <= tail_next;
      headV_reg <= headV_next;
      tailV_reg <= tailV_next;
    end
  end

  assign inReady = !tailV_reg; // Full only when both entries hold words
  assign outData = head_reg;
  assign outValid = headV_reg;

endmodule

// ===== tb/shp_port_checker.sv
// Checker for the serial host port, attached by the bind below.
// Assumes the system clock and its synchronous active-low reset.
`timescale 1ns/1ps
module shp_port_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic attnOut,
  input wire logic attnOe,
  input wire logic [1:0] txEmpty,
  input wire logic [1:0] rxNotEmpty,
  input wire logic [7:0] txData,
  input wire logic txChan,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [3:0] spreadDeviationSelect,
  input wire logic [15:0] devCycles
);
  logic [7:0] quiet_reg = 8'h00;
  wire anyCond = |{txEmpty, rxNotEmpty};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Clocks since select or serial clock last moved
  always_ff @(posedge clk)
    if ($changed(csN) || $changed(spiClk))
      quiet_reg <= 8'h00;
    else if (quiet_reg != 8'hFF)
      quiet_reg <= quiet_reg + 8'h01;
  // Deviation count expected for a code
  function automatic logic [7:0] devOf(input logic [1:0] code);
    if (code == shp_pkg::DEV_NARROW)
      return 8'(shp_pkg::DEV_NARROW_CYC);
    if (code == shp_pkg::DEV_WIDE)
      return 8'(shp_pkg::DEV_WIDE_CYC);
    return 8'h00;
  endfunction
  // Select held idle or busy long enough for the sync to follow
  sequence selIdle;
    csN [*8];
  endsequence
  sequence selBusy;
    !csN [*8];
  endsequence
  attn_set_a: assert property ($rose(attnOe) |-> $past(anyCond))
    else $error("attention raised without a queue condition");
  attn_release_a: assert property ($fell(attnOe) |-> quiet_reg < 8'h0C)
    else $error("attention released away from a word end");
  attn_pin_a: assert property (attnOut == 1'b0)
    else $error("attention pin drives high");
  miso_edge_a: assert property ($changed(miso) |-> !spiClk || csN)
    else $error("data out moved outside a falling edge");
  oe_drop_a: assert property (selIdle |-> !misoOe)
    else $error("data out driven while deselected");
  oe_rise_a: assert property (selBusy |-> misoOe)
    else $error("data out not driven while selected");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txChan))
    else $error("transmit head moved while stalled");
  dev_map_a: assert property ($stable(spreadDeviationSelect) |->
    devCycles == {devOf(spreadDeviationSelect[3:2]), devOf(spreadDeviationSelect[1:0])})
    else $error("deviation count does not match its code");
  sel_quiet_a: assert property ($changed(spreadDeviationSelect) |-> quiet_reg < 8'h0C)
    else $error("control changed without serial traffic");
endmodule

bind shp_port_ctrl shp_port_checker shp_port_checker_inst (.clk(clk), .resetn(resetn), .spiClk(spiClk),
  .csN(csN), .miso(miso), .misoOe(misoOe), .attnOut(attnOut), .attnOe(attnOe), .txEmpty(txEmpty),
  .rxNotEmpty(rxNotEmpty), .txData(txData), .txChan(txChan), .txValid(txValid), .txReady(txReady),
  .spreadDeviationSelect(spreadDeviationSelect), .devCycles(devCycles));

// ===== tb/shp_host_model.sv
// Host model: serial clock master for the port under test.
// Assumes its tasks are called from one process at a time.
`timescale 1ns/1ps
module shp_host_model (
  output logic spiClk,
  output logic csN,
  output logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  // Idle: deselected, clock parked low
  initial
  begin
    spiClk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // Sends nBits from the top of d; rd keeps the last eight bits read back
  task automatic frame(input logic [39:0] d, input int nBits, output logic [7:0] rd);
    csN = 1'b0;
    for (int i = 0; i < nBits; i++)
    begin
      mosi = d[39 - i];
      #62.5 spiClk = 1'b1;
      rd = {rd[6:0], misoOe ? miso : 1'b1};
      #62.5 spiClk = 1'b0;
    end
    #62.5 csN = 1'b1;
    mosi = ~mosi;
    #100;
  endtask
  // Clock and data wiggle while deselected
  task automatic noise();
    mosi = 1'b0; // Every clock rise then sees a one, which would form a 0xFF command byte
    for (int i = 0; i < 16; i++)
    begin
      mosi = ~mosi;
      #62.5 spiClk = ~spiClk;
    end
  endtask
endmodule

// ===== tb/tb_top.sv
// Bench top: port under test, host model, row table and hand tests.
// Assumes the host model owns the serial pins.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [15:0] frm; logic [3:0] sel; logic [15:0] dev;} shp_row_t;
  logic clk, resetn, spiClk, csN, mosi, miso, misoOe, attnOut, attnOe, txChan, txValid, txReady;
  logic [1:0] txEmpty, rxNotEmpty;
  logic [7:0] txData, rd;
  logic [3:0] spreadDeviationSelect;
  logic [15:0] devCycles;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  // Command and control byte, expected select and deviation counts
  shp_row_t rows [6] = '{'{16'h0008, 4'h2, 16'h0028}, '{16'h0104, 4'h6, 16'h5028},
    '{16'h000C, 4'h7, 16'h5000}, '{16'hFD08, 4'hB, 16'h2800}, '{16'h0100, 4'h3, 16'h0000},
    '{16'h0000, 4'h0, 16'h0000}};
  // Shared request line with its pull-up
  wire attnLine = attnOe ? attnOut : 1'b1;
  shp_port_ctrl shp_port_ctrl_inst (.clk(clk), .resetn(resetn), .spiClk(spiClk), .csN(csN), .mosi(mosi),
    .miso(miso), .misoOe(misoOe), .attnOut(attnOut), .attnOe(attnOe), .txEmpty(txEmpty),
    .rxNotEmpty(rxNotEmpty), .txData(txData), .txChan(txChan), .txValid(txValid), .txReady(txReady),
    .spreadDeviationSelect(spreadDeviationSelect), .devCycles(devCycles));
  shp_host_model shp_host_model_inst (.spiClk(spiClk), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe));
  // System clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string msg);
    checks++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic frame(input logic [39:0] d, input int n);
    shp_host_model_inst.frame(d, n, rd);
    tick(4);
  endtask
  // Checks the buffer head, then takes it with a one-clock ready
  task automatic pop(input logic [7:0] d, input logic ch);
    check({6'h00, txValid, txChan, txData}, {6'h00, 1'b1, ch, d}, "tx head");
    txReady = 1'b1;
    tick(1);
    txReady = 1'b0;
    tick(4);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Cuts a hang short; the tests need about 3800 clocks
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // Main sequence: reset, row table, then hand tests
  initial
  begin
    txEmpty = 2'h0;
    rxNotEmpty = 2'h0;
    txReady = 1'b0;
    // Reset falls after time zero so the serial-side async clears see an edge
    #1 resetn = 1'b0;
    tick(16);
    check({misoOe, txValid, attnOe, 9'h000, spreadDeviationSelect}, 16'h0000, "reset outputs");
    check(devCycles, 16'h0000, "reset counts");
    resetn = 1'b1;
    tick(4);
    foreach (rows[i])
    begin
      frame({rows[i].frm, 24'h000000}, 16);
      check({12'h000, spreadDeviationSelect}, {12'h000, rows[i].sel}, "select");
      check(devCycles, rows[i].dev, "counts");
    end
    shp_host_model_inst.noise();
    tick(8);
    check({txValid, 11'h000, spreadDeviationSelect}, 16'h0000, "idle noise");
    frame({8'hFF, 32'h00000000}, 4);
    frame({16'h0004, 24'h000000}, 16);
    check({spreadDeviationSelect, devCycles[11:0]}, 16'h1050, "after partial");
    frame({16'h0001, 24'h000000}, 16);
    txEmpty = 2'h1;
    tick(2);
    check({15'h0000, attnLine}, 16'h0000, "attn set");
    txEmpty = 2'h0;
    tick(8);
    check({15'h0000, attnLine}, 16'h0000, "attn held");
    frame({16'h0102, 24'h000000}, 16);
    check({15'h0000, attnLine}, 16'h0001, "attn cleared");
    rxNotEmpty = 2'h2;
    tick(2);
    check({15'h0000, attnLine}, 16'h0000, "attn rx");
    frame({16'h0100, 24'h000000}, 16);
    check({8'h00, rd & 8'h81}, 16'h0001, "status");
    check({15'h0000, attnLine}, 16'h0001, "attn masked");
    rxNotEmpty = 2'h0;
    frame({8'h03, 32'h11223344}, 40);
    pop(8'h11, 1'b1);
    pop(8'h22, 1'b1);
    pop(8'h33, 1'b1);
    check({15'h0000, txValid}, 16'h0000, "overflow dropped");
    frame({16'h02A5, 24'h000000}, 16);
    pop(8'hA5, 1'b0);
    frame({16'h0008, 24'h000000}, 16);
    frame({16'h025A, 24'h000000}, 16);
    resetn = 1'b0;
    tick(3);
    check({txValid, 11'h000, spreadDeviationSelect}, 16'h0000, "second reset");
    resetn = 1'b1;
    tick(2);
    check({misoOe, txValid, attnOe, 9'h000, spreadDeviationSelect}, 16'h0000, "after release");
    frame({16'h0104, 24'h000000}, 16);
    check({spreadDeviationSelect, devCycles[15:4]}, 16'h4500, "after reset frame");
    report_and_stop();
  end
endmodule
